// ==== shared/tsa_pkg.sv ====
// package of constants and types for the temperature status and alert flag block
package tsa_pkg;
   localparam logic [7:0] TSA_PTR_STATUS  = 8'h02;
   localparam logic [7:0] TSA_PTR_HYST    = 8'h21;
   localparam logic [7:0] TSA_HYST_RESET  = 8'h0A;
   localparam int         TSA_CFG1_PINSEL = 5;
   localparam int         TSA_B_BUSY      = 7;
   localparam int         TSA_B_LOC_UP    = 6;
   localparam int         TSA_B_LOC_LO    = 5;
   localparam int         TSA_B_REM_UP    = 4;
   localparam int         TSA_B_REM_LO    = 3;
   localparam int         TSA_B_OPEN      = 2;
   localparam int         TSA_B_ROT       = 1;
   localparam int         TSA_B_LOT       = 0;
   localparam int         TSA_B_CHIGH     = 4;
   localparam int         TSA_B_CLOW      = 3;
   localparam int         TSA_B_COT       = 1;
   // one finished conversion result with its limits
   typedef struct packed {
      logic [7:0] temp;
      logic [7:0] high_lim;
      logic [7:0] low_lim;
      logic [7:0] ot_lim;
   } tsa_conv_t;
endpackage

// ==== hw/tsa_status_alert.sv ====
// status register and alert flag logic of the temperature monitor
`timescale 1ns/100ps
module tsa_status_alert
   import tsa_pkg::*;
#(
   parameter bit COMBINED = 1'b0
) (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       resetn,
   // converter side
   input  wire logic       conv_busy,
   input  wire logic       conv_done,
   input  wire logic       conv_remote,
   input  wire logic       open_detect,
   input  wire tsa_conv_t  conv,
   // configuration
   input  wire logic [7:0] cfg1,
   input  wire logic [7:0] hyst,
   // register read port
   input  wire logic       rd_stb,
   input  wire logic [7:0] rd_ptr,
   output logic [7:0]      rd_data,
   // alert
   input  wire logic       alert_resp,
   output logic            alert_out,
   output logic            alert_oe
);
   logic       rst_s1_r, rst_s2_r;
   logic       rstn;
   logic       lhi_r, llo_r, rhi_r, rlo_r, open_r, lot_r, rot_r, busy_r;
   logic       lhi_live_r, rhi_live_r;
   logic       lhi_c_r, llo_c_r, rhi_c_r, rlo_c_r;
   logic       alert_r;
   logic [7:0] status;
   logic [7:0] flags_prev_r;
   logic [8:0] hi_rel, ot_rel;
   logic       pinsel, over_hi, under_lo, over_ot, hi_held, ot_held;
   logic       rd_hit, clr_pend_r;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rst_s1_r <= 1'b0;
         rst_s2_r <= 1'b0;
      end else begin
         rst_s1_r <= 1'b1;
         rst_s2_r <= rst_s1_r;
      end
   end
   assign rstn = rst_s2_r;

   assign pinsel   = cfg1[TSA_CFG1_PINSEL];
   assign hi_rel   = {1'b0, conv.high_lim} - {1'b0, hyst};
   assign ot_rel   = {1'b0, conv.ot_lim} - {1'b0, hyst};
   assign over_hi  = conv.temp > conv.high_lim;
   assign under_lo = conv.temp < conv.low_lim;
   assign over_ot  = conv.temp > conv.ot_lim;
   // negative release point means any reading keeps the flag
   assign hi_held  = hi_rel[8] | ({1'b0, conv.temp} > hi_rel);
   assign ot_held  = ot_rel[8] | ({1'b0, conv.temp} > ot_rel);
   assign rd_hit   = rd_stb && (rd_ptr == TSA_PTR_STATUS);

   // busy follows converter
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) busy_r <= 1'b0;
      else       busy_r <= conv_busy;
   end

   // clear one cycle after the byte is latched out
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) clr_pend_r <= 1'b0;
      else       clr_pend_r <= rd_hit;
   end

   // live conditions, refreshed at end of own channel conversion
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         lot_r <= 1'b0; rot_r <= 1'b0; lhi_live_r <= 1'b0; rhi_live_r <= 1'b0;
         lhi_c_r <= 1'b0; llo_c_r <= 1'b0; rhi_c_r <= 1'b0; rlo_c_r <= 1'b0;
      end else if (conv_done) begin
         if (conv_remote) begin
            rot_r      <= rot_r ? ot_held : over_ot;
            rhi_live_r <= rhi_live_r ? hi_held : over_hi;
            rhi_c_r    <= over_hi;
            rlo_c_r    <= under_lo;
         end else begin
            lot_r      <= lot_r ? ot_held : over_ot;
            lhi_live_r <= lhi_live_r ? hi_held : over_hi;
            lhi_c_r    <= over_hi;
            llo_c_r    <= under_lo;
         end
      end
   end

   // latched flags; a new event wins over the read clear
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         lhi_r <= 1'b0; llo_r <= 1'b0; rhi_r <= 1'b0; rlo_r <= 1'b0; open_r <= 1'b0;
      end else begin
         if (clr_pend_r) begin
            if (!lhi_c_r) lhi_r <= 1'b0;
            if (!llo_c_r) llo_r <= 1'b0;
            if (!rhi_c_r) rhi_r <= 1'b0;
            if (!rlo_c_r) rlo_r <= 1'b0;
            open_r <= 1'b0;
         end
         if (conv_done && !conv_remote && over_hi) lhi_r <= 1'b1;
         if (conv_done && !conv_remote && under_lo) llo_r <= 1'b1;
         if (conv_done && conv_remote && over_hi) rhi_r <= 1'b1;
         if (conv_done && conv_remote && under_lo) rlo_r <= 1'b1;
         if (conv_busy && conv_remote && open_detect) open_r <= 1'b1;
      end
   end

   always_comb begin
      status = 8'h00;
      status[TSA_B_BUSY] = busy_r;
      status[TSA_B_OPEN] = open_r;
      if (COMBINED) begin
         status[TSA_B_CHIGH] = pinsel ? (lhi_live_r | rhi_live_r)
                                      : (lhi_r | rhi_r);
         status[TSA_B_CLOW]  = llo_r | rlo_r;
         status[TSA_B_COT]   = lot_r | rot_r;
      end else begin
         status[TSA_B_LOC_UP] = pinsel ? lhi_live_r : lhi_r;
         status[TSA_B_REM_UP] = pinsel ? rhi_live_r : rhi_r;
         status[TSA_B_LOC_LO] = llo_r;
         status[TSA_B_REM_LO] = rlo_r;
         status[TSA_B_ROT]   = rot_r;
         status[TSA_B_LOT]   = lot_r;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn)       rd_data <= 8'h00;
      else if (rd_hit) rd_data <= status;
   end

   // alert sources: high, low, open bits of the active layout
   logic [7:0] alert_mask;
   assign alert_mask = COMBINED ? 8'h1C : 8'h7C;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) flags_prev_r <= 8'h00;
      else       flags_prev_r <= status & alert_mask;
   end

   // only the alert response releases; reads do not
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) alert_r <= 1'b0;
      else if (!pinsel && |((status & alert_mask) & ~flags_prev_r)) alert_r <= 1'b1;
      else if (alert_resp) alert_r <= 1'b0;
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         alert_out <= 1'b0;
         alert_oe  <= 1'b0;
      end else begin
         alert_out <= 1'b0;
         alert_oe  <= pinsel ? (status[TSA_B_LOC_UP] | status[TSA_B_REM_UP] |
                                (COMBINED & status[TSA_B_CHIGH])) : alert_r;
      end
   end

   a_busy_follow: assert property (@(posedge clk) disable iff (!rstn)
      busy_r == $past(conv_busy)) else $error("busy bit wrong");
   a_read_clears_open: assert property (@(posedge clk) disable iff (!rstn)
      rd_hit && !(conv_busy && conv_remote && open_detect) ##1
      !(conv_busy && conv_remote && open_detect) |=> !open_r)
      else $error("open not cleared by read");
   a_open_holds: assert property (@(posedge clk) disable iff (!rstn)
      open_r && !clr_pend_r |=> open_r) else $error("open dropped");
   a_read_data: assert property (@(posedge clk) disable iff (!rstn)
      rd_hit |=> rd_data == $past(status)) else $error("read data wrong");
   a_alert_sticky: assert property (@(posedge clk) disable iff (!rstn)
      alert_r && !alert_resp |=> alert_r) else $error("alert released");
   a_alert_rise: assert property (@(posedge clk) disable iff (!rstn)
      !pinsel && $rose(status[TSA_B_OPEN]) |=> alert_r)
      else $error("alert missed");
   a_comb_zero: assert property (@(posedge clk) disable iff (!rstn)
      COMBINED |-> status[6:5] == 2'b00 && !status[0]) else $error("zero bits set");
   a_low_latch: assert property (@(posedge clk) disable iff (!rstn)
      conv_done && !conv_remote && under_lo |=> llo_r) else $error("low not latched");
   c_open_read: cover property (@(posedge clk) disable iff (!rstn) open_r ##1 clr_pend_r);
   c_alert_resp: cover property (@(posedge clk) disable iff (!rstn) alert_r ##1 !alert_r);
   c_lot_set: cover property (@(posedge clk) disable iff (!rstn) $rose(lot_r));
endmodule

// ==== dv/tsa_host_model.sv ====
// host-side model: status reads and alert response
`timescale 1ns/100ps
module tsa_host_model (
   // clock
   input  wire logic       clk,
   // read port
   output logic            rd_stb = 1'b0,
   output logic [7:0]      rd_ptr = 8'h00,
   input  wire logic [7:0] rd_data,
   // alert pin, pulled up when released
   output logic            alert_resp = 1'b0,
   input  wire logic       alert_out,
   input  wire logic       alert_oe,
   output wire logic       alert_line
);
   assign alert_line = alert_oe ? alert_out : 1'b1;
   task automatic rd(input logic [7:0] p, output logic [7:0] d);
      @(posedge clk);
      rd_stb <= 1'b1;
      rd_ptr <= p;
      @(posedge clk);
      rd_stb <= 1'b0;
      rd_ptr <= ~p;
      @(posedge clk);
      #1 d = rd_data;
   endtask
   // with pinsel clear, clearing flags leaves the pin low, only this releases it
   task automatic ack;
      @(posedge clk);
      alert_resp <= 1'b1;
      @(posedge clk);
      alert_resp <= 1'b0;
   endtask
endmodule

// ==== dv/temp_status_alert_flags_tb_top.sv ====
// self-checking bench for the status and alert flag block
`timescale 1ns/100ps
module temp_status_alert_flags_tb_top;
   import tsa_pkg::*;
   logic       clk = 1'b0, resetn = 1'b0, conv_busy = 1'b0, conv_done = 1'b0;
   logic       conv_remote = 1'b0, open_detect = 1'b0, r, lo, lh, ro, rh;
   logic       rd_stb, alert_resp, alert_out, alert_oe, alert_line;
   logic       alert_out2, alert_oe2;
   logic [7:0] rd_data2;
   logic [7:0] cfg1 = 8'h00, hyst = TSA_HYST_RESET, rd_ptr, rd_data, d, e, t;
   tsa_conv_t  conv = '0;
   int         fails = 0, samples_checked = 0, i;
   always #20 clk = ~clk;
   tsa_status_alert #(.COMBINED(1'b0)) tsa_status_alert_inst (.clk(clk), .resetn(resetn),
      .conv_busy(conv_busy), .conv_done(conv_done), .conv_remote(conv_remote),
      .open_detect(open_detect), .conv(conv), .cfg1(cfg1), .hyst(hyst), .rd_stb(rd_stb),
      .rd_ptr(rd_ptr), .rd_data(rd_data), .alert_resp(alert_resp), .alert_out(alert_out),
      .alert_oe(alert_oe));
   // combined layout copy on the same converter and host signals
   tsa_status_alert #(.COMBINED(1'b1)) tsa_status_alert_inst2 (.clk(clk), .resetn(resetn),
      .conv_busy(conv_busy), .conv_done(conv_done), .conv_remote(conv_remote),
      .open_detect(open_detect), .conv(conv), .cfg1(cfg1), .hyst(hyst), .rd_stb(rd_stb),
      .rd_ptr(rd_ptr), .rd_data(rd_data2), .alert_resp(alert_resp), .alert_out(alert_out2),
      .alert_oe(alert_oe2));
   tsa_host_model tsa_host_model_inst (.clk(clk), .rd_stb(rd_stb), .rd_ptr(rd_ptr),
      .rd_data(rd_data), .alert_resp(alert_resp), .alert_out(alert_out),
      .alert_oe(alert_oe), .alert_line(alert_line));
   task automatic chk(input string n, input logic [7:0] x, input logic [7:0] g);
      samples_checked++;
      if (g !== x) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", n, x, g);
      end
   endtask
   task automatic tally_and_finish;
      if (fails == 0 && samples_checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // limits: high 60, low 20, overtemp 50
   task automatic cv(input logic rm, input logic [7:0] tp, input logic od);
      @(posedge clk);
      conv_busy   <= 1'b1;
      conv_remote <= rm;
      open_detect <= od;
      @(posedge clk);
      conv_done <= 1'b1;
      conv      <= '{tp, 8'h3C, 8'h14, 8'h32};
      @(posedge clk);
      conv_done   <= 1'b0;
      conv_busy   <= 1'b0;
      open_detect <= 1'b0;
   endtask
   task automatic st(output logic [7:0] v);
      tsa_host_model_inst.rd(TSA_PTR_STATUS, v);
   endtask
   // combined layout expected from the per-channel one
   function automatic logic [7:0] cmb(input logic [7:0] x);
      return {x[7], 2'b00, x[6] | x[4], x[5] | x[3], x[2], x[1] | x[0], 1'b0};
   endfunction
   // release never happens when hysteresis exceeds the limit
   function automatic logic hy(input logic c, input logic [7:0] tp, input logic [7:0] lim);
      if (tp > lim)
         return 1'b1;
      if (lim >= hyst && tp <= lim - hyst)
         return 1'b0;
      return c;
   endfunction
   initial begin
      void'($urandom(36773));
      repeat (4) @(posedge clk);
      resetn <= 1'b1;
      repeat (3) @(posedge clk);
      st(d);
      chk("reset", 8'h00, d);
      chk("comb reset", 8'h00, rd_data2);
      conv_busy <= 1'b1;
      st(d);
      chk("busy", 8'h80, d);
      chk("comb busy", 8'h80, rd_data2);
      conv_busy <= 1'b0;
      cv(1'b0, 8'h46, 1'b0);
      for (i = 0; i < 8 && alert_oe !== 1'b1; i++) @(posedge clk);
      chk("alert set", 8'h00, {7'h00, alert_line});
      chk("comb alert set", 8'h01, {7'h00, alert_oe2});
      st(d);
      chk("status", 8'h41, d);
      chk("comb", cmb(8'h41), rd_data2);
      cv(1'b0, 8'h1E, 1'b1);
      st(d);
      chk("status", 8'h40, d);
      chk("comb", cmb(8'h40), rd_data2);
      st(d);
      chk("status", 8'h00, d);
      chk("comb", 8'h00, rd_data2);
      chk("alert held", 8'h00, {7'h00, alert_line});
      tsa_host_model_inst.ack();
      repeat (2) @(posedge clk);
      chk("alert free", 8'h01, {7'h00, alert_line});
      cv(1'b1, 8'h1E, 1'b1);
      st(d);
      chk("status", 8'h04, d);
      chk("comb", cmb(8'h04), rd_data2);
      cv(1'b1, 8'h0A, 1'b0);
      st(d);
      chk("status", 8'h08, d);
      chk("comb", cmb(8'h08), rd_data2);
      tsa_host_model_inst.rd(8'h21, e);
      chk("other ptr", 8'h08, e);
      cv(1'b1, 8'h1E, 1'b0);
      st(d);
      chk("status", 8'h08, d);
      st(d);
      chk("status", 8'h00, d);
      chk("comb", 8'h00, rd_data2);
      tsa_host_model_inst.ack();
      cfg1 <= 8'h20;
      hyst <= 8'($urandom_range(15));
      {lo, lh, ro, rh} = 4'h0;
      for (i = 0; i < 60; i++) begin
         r = 1'($urandom_range(1));
         t = 8'($urandom_range(80, 30));
         cv(r, t, 1'b0);
         if (r) begin
            ro = hy(ro, t, 8'h32);
            rh = hy(rh, t, 8'h3C);
         end else begin
            lo = hy(lo, t, 8'h32);
            lh = hy(lh, t, 8'h3C);
         end
         st(d);
         chk("live", {1'b0, lh, 1'b0, rh, 2'b00, ro, lo}, d);
         chk("comb live", cmb({1'b0, lh, 1'b0, rh, 2'b00, ro, lo}), rd_data2);
         chk("pin", {7'h00, ~(lh | rh)}, {7'h00, alert_line});
      end
      tally_and_finish();
   end
endmodule
